// [hw/eil_defines.vh]
// Constants for the external interrupt latch block
`ifndef EIL_DEFINES_VH
`define EIL_DEFINES_VH
`define EIL_ADDR_STATUS_CTRL 8'h1E
`define EIL_ADDR_IRQ_STATUS 8'h20
`define EIL_ADDR_IRQ_MASK 8'h21
`define EIL_BIT_MODE 0
`define EIL_BIT_MASK 1
`define EIL_BIT_ACK 2
`define EIL_BIT_PEND 3
`define EIL_RST_STATUS_CTRL 8'h00
`define EIL_RST_IRQ_MASK 8'h00
`define EIL_EVT_LATCH 0
`define EIL_EVT_RELEASE 1
`define EIL_EVT_WIDTH 2
`endif

// [hw/eil_pin_sync.v]
// Two-stage synchroniser with falling-edge detect
`timescale 1ns/100ps
module eil_pin_sync (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_rst_b,
	// Pin and result
	input wire i_pin_b,
	output reg o_level,
	output reg o_fall
);
	reg meta;
	reg prev;
	// RULE17: sync and compare
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta <= 1'b1;
			o_level <= 1'b1;
			prev <= 1'b1;
			o_fall <= 1'b0;
		end else begin
			meta <= i_pin_b;
			o_level <= meta;
			prev <= o_level;
			o_fall <= prev & ~o_level;
		end
	end
endmodule // eil_pin_sync

// [hw/eil_top.v]
// External interrupt latch with status and control register
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`include "eil_defines.vh"
// Overview of operation
// RULE1: A low on the pin, per the sensitivity, sets the latch.
// RULE2: A vector fetch acknowledge clears the latch with no software.
// RULE3: Writing one to the clear bit (bit 2) clears the latch.
// RULE4: Any reset clears the latch.
// RULE5: Falling edges always trigger; a select bit adds low levels.
// RULE6: Edge-only mode holds the request until an acknowledge or reset.
// RULE7: Level mode holds the request until acknowledge and pin high.
// RULE8: In level mode acknowledge and pin return may come in any order.
// RULE9: Reset clears latch and select bit even with the pin held low; a pin still low after reset release reads as a falling edge and sets the latch.
// RULE10: A set mask bit withholds the request from the priority logic.
// RULE11: The processor global mask blocks all requests outside here.
// RULE12: Register at 0x1E: bits 7-4 zero, 3 pending, 2 clear, 1 mask, 0 mode.
// RULE13: Select one means edges and levels; zero means edges only.
// RULE14: The pending flag reads the latch regardless of the mask.
// RULE15: The clear bit always reads zero.
// RULE16: Writing one to the mask disables requests, zero enables.
// RULE17: The pin is synchronised and edges found from two samples.
module eil_top #(
	parameter ADDR_W = 8,
	parameter DATA_W = 8
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_rst_b,
	// Register port
	input wire [ADDR_W-1:0] i_addr,
	input wire [DATA_W-1:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [DATA_W-1:0] o_rdata,
	// External pin and processor side
	input wire i_irq_pin_b,
	input wire i_vector_fetch,
	output reg o_irq_req,
	output reg o_pin_level,
	// Block interrupt
	output reg o_int
);
	wire pin_level;
	wire pin_fall;
	reg latch;
	reg pend;
	reg next_pend;
	wire level_ev;
	reg mode;
	reg request_mask_bit;
	reg [`EIL_EVT_WIDTH-1:0] irq_status;
	reg [`EIL_EVT_WIDTH-1:0] irq_mask;
	reg [DATA_W-1:0] next_rdata;
	reg next_latch;
	wire wr_ctrl;
	wire ack;
	wire set_ev;
	wire [`EIL_EVT_WIDTH-1:0] evt;

	function hit;
		input [ADDR_W-1:0] a;
		input [7:0] r;
		begin
			hit = (a == r[ADDR_W-1:0]);
		end
	endfunction

	eil_pin_sync u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_pin_b(i_irq_pin_b),
		.o_level(pin_level),
		.o_fall(pin_fall)
	);

	assign wr_ctrl = i_wr & hit(i_addr, `EIL_ADDR_STATUS_CTRL);
	// RULE2: vector fetch acknowledge
	// RULE3: software acknowledge
	assign ack = i_vector_fetch | (wr_ctrl & i_wdata[`EIL_BIT_ACK]);
	// RULE5: falling edge latches
	assign set_ev = pin_fall;
	// RULE13: mode adds level
	assign level_ev = mode & ~pin_level;

	// RULE6: edge mode hold
	// RULE7: level mode hold
	// RULE8: either order release
	always @* begin
		next_latch = latch;
		if (ack)
			next_latch = 1'b0;
		// RULE1: new trigger wins
		if (set_ev)
			next_latch = 1'b1;
		// In level mode a low level holds request past ack
		next_pend = next_latch | level_ev;
	end

	assign evt[`EIL_EVT_LATCH] = ~pend & next_pend;
	assign evt[`EIL_EVT_RELEASE] = pend & ~next_pend;

	// RULE4: reset clears latch
	// RULE9: reset clears mode
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			latch <= 1'b0;
			pend <= 1'b0;
			mode <= 1'b0;
			request_mask_bit <= 1'b0;
			irq_status <= {`EIL_EVT_WIDTH{1'b0}};
			irq_mask <= {`EIL_EVT_WIDTH{1'b0}};
		end else begin
			latch <= next_latch;
			pend <= next_pend;
			// RULE16: mask write
			if (wr_ctrl) begin
				mode <= i_wdata[`EIL_BIT_MODE];
				request_mask_bit <= i_wdata[`EIL_BIT_MASK];
			end
			if (i_wr & hit(i_addr, `EIL_ADDR_IRQ_MASK))
				irq_mask <= i_wdata[`EIL_EVT_WIDTH-1:0];
			// Set wins over clear
			if (i_wr & hit(i_addr, `EIL_ADDR_IRQ_STATUS))
				irq_status <= (irq_status &
					~i_wdata[`EIL_EVT_WIDTH-1:0]) | evt;
			else
				irq_status <= irq_status | evt;
		end
	end

	// Read mux
	always @* begin
		next_rdata = {DATA_W{1'b0}};
		if (hit(i_addr, `EIL_ADDR_STATUS_CTRL)) begin
			// RULE12: register layout
			// RULE14: pending unmasked
			// RULE15: clear reads zero
			next_rdata[`EIL_BIT_PEND] = pend;
			next_rdata[`EIL_BIT_MASK] = request_mask_bit;
			next_rdata[`EIL_BIT_MODE] = mode;
		end else if (hit(i_addr, `EIL_ADDR_IRQ_STATUS)) begin
			next_rdata[`EIL_EVT_WIDTH-1:0] = irq_status;
		end else if (hit(i_addr, `EIL_ADDR_IRQ_MASK)) begin
			next_rdata[`EIL_EVT_WIDTH-1:0] = irq_mask;
		end
	end

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= {DATA_W{1'b0}};
			o_irq_req <= 1'b0;
			o_pin_level <= 1'b1;
			o_int <= 1'b0;
		end else begin
			o_rdata <= i_rd ? next_rdata : {DATA_W{1'b0}};
			// RULE10: mask gates request
			// RULE11: global mask is outside
			o_irq_req <= next_pend & ~request_mask_bit;
			o_pin_level <= pin_level;
			o_int <= |(irq_status & irq_mask);
		end
	end
endmodule // eil_top

// [testbench/eil_assertions.sv]
// Checker for the interrupt latch ports
`timescale 1ns/100ps
module eil_chk(input wire i_clk_sys,i_rst_b,i_wr,i_rd,i_irq_pin_b,
	i_vector_fetch,o_irq_req,o_pin_level,
	input wire [7:0] i_addr,i_wdata,o_rdata);
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_rst_b);
reg m;
always @(posedge i_clk_sys or negedge i_rst_b)
	if(!i_rst_b) m<=1'h0;
	else if(i_wr&&i_addr==8'h1E) m<=i_wdata[1];
sequence s_q; (i_irq_pin_b&&o_pin_level)[*3]; endsequence
a_reset_idle: assert property($rose(i_rst_b)|->!o_irq_req)
	else $error("request after reset");
a_pin_sync: assert property(
	$past(i_rst_b,1)&&$past(i_rst_b,2)&&$past(i_rst_b,3)
	|->o_pin_level==$past(i_irq_pin_b,3)) else $error("sync");
a_fall_sets: assert property($fell(o_pin_level)&&!m|->##[1:3] o_irq_req)
	else $error("fall not latched");
a_fetch_clears: assert property(
	s_q ##0 i_vector_fetch|=>!o_irq_req) else $error("fetch kept request");
a_write_clears: assert property(
	s_q ##0 (i_wr&&i_addr==8'h1E&&i_wdata[2])|=>!o_irq_req) else $error("ack");
a_mask_hides: assert property(m&&$past(m)|->!o_irq_req)
	else $error("masked request seen");
a_read_idle: assert property(!$past(i_rd)|->o_rdata==8'h00)
	else $error("data outside read");
a_read_fixed: assert property(
	$past(i_rd&&i_addr==8'h1E)|->o_rdata[7:4]==4'h0&&!o_rdata[2]) else $error("r");
endmodule // eil_chk
bind eil_top eil_chk i_chk(.*);

// [testbench/eil_pin_src.sv]
// Outside circuitry driving the interrupt pin
`timescale 1ns/100ps
module eil_pin_src(input wire i_clk_sys,i_low,output logic o_pin_b);
initial o_pin_b=1'h1;
always @(posedge i_clk_sys) o_pin_b<=!i_low;
endmodule // eil_pin_src

// [testbench/eil_top_bench.sv]
// Bench for the external interrupt latch
`timescale 1ns/100ps
module eil_top_bench;
logic i_clk_sys=0,i_rst_b=0,i_wr=0,i_rd=0,i_vector_fetch=0,low=0;
logic [7:0] i_addr=0,i_wdata=0;
wire [7:0] o_rdata;
wire i_irq_pin_b,o_irq_req,o_pin_level,o_int;
int bad_count=0,checked=0;
always #2 i_clk_sys=~i_clk_sys;
eil_pin_src i_src(.i_clk_sys,.i_low(low),.o_pin_b(i_irq_pin_b));
eil_top i_dut(.*);
task e; @(posedge i_clk_sys); endtask
task cyc(input int n); repeat(n) e; #1; endtask
task chk(input logic [7:0] g,x); checked++;
	if(g!==x) begin bad_count++; $display("BAD %0t got %h not %h",$time,g,x); end
endtask
task w(input logic [7:0] a,d); e; i_addr<=a; i_wdata<=d; i_wr<=1; e; i_wr<=0;
endtask
task r(input logic [7:0] a,x); e; i_addr<=a; i_rd<=1; e; i_rd<=0;
	#1 chk(o_rdata,x); endtask
task f; e; i_vector_fetch<=1; e; i_vector_fetch<=0; cyc(2); endtask
task p; e; low<=1; cyc(3); e; low<=0; cyc(8); endtask
task t_edge; p; chk(o_irq_req,1);
	r(8'h1E,8'h08);
	f; chk(o_irq_req,0);
	$display("edge done"); endtask
task t_level; w(8'h1E,8'h01); low<=1; cyc(8); chk(o_irq_req,1);
	w(8'h1E,8'h05); cyc(4); chk(o_irq_req,1);
	low<=0; cyc(8); chk(o_irq_req,0);
	p; chk(o_irq_req,1);
	f; chk(o_irq_req,0);
	low<=1; cyc(8); i_rst_b<=0; #1 chk(o_irq_req,0);
	cyc(2); i_rst_b<=1; low<=0; cyc(8); f; r(8'h1E,8'h00);
	$display("level done"); endtask
task t_mask; w(8'h1E,8'h02); p; chk(o_irq_req,0);
	r(8'h1E,8'h0A);
	w(8'h1E,8'h04); cyc(2); chk(o_irq_req,0);
	r(8'h1E,8'h00);
	$display("mask done"); endtask
task t_int; r(8'h20,8'h03); w(8'h20,8'h03); r(8'h20,8'h00);
	chk(o_int,0); w(8'h21,8'h03); r(8'h21,8'h03); r(8'h40,8'h00);
	p; chk(o_int,1);
	f; w(8'h20,8'h03); cyc(2); chk(o_int,0);
	$display("irq done"); endtask
task conclude; $display("checks %0d bad %0d",checked,bad_count);
	if(bad_count==0&&checked>0) $display("No errors found");
	else $display("Errors were found");
	$finish; endtask
initial begin
	repeat(8) e;
	i_rst_b<=1;
	t_edge; t_level; t_mask; t_int; conclude;
end
endmodule // eil_top_bench
